// [rtl/amp_fault_protection_supervisor.sv]
`include "amp_fault_cfg.svh"
// Contract
// R01: clip select 0 smooth, 1 maximum power
// R02: pwm rate follows sample rate family
// R03: source gives supported bit clock ratio
// R04: over temperature floats outputs, sets flag
// R05: thermal clears by host or timer
// R06: no recovery holds until off/on cycle; the code also releases it on a host clear
// R07: over current floats outputs, sets flag
// R08: current clears by host or timer
// R09: no recovery holds until off/on cycle; the code also releases it on a host clear
// R10: pwm below 96 khz floats, self restarts
// R11: pwm above 1031 khz floats, self restarts
// R12: each fault flag readable in status
// R13: bad bit clock cuts audio, floats outputs
// R14: ratio 16,32,48,64,128 within one accepted
// R15: float output is or of faults; the code also floats it in off mode
module amp_fault_protection_supervisor #(
  parameter logic [31:0] OTP_T1_CYC = 32'(`OTP_T1_CYC),
  parameter logic [31:0] OTP_T2_CYC = 32'(`OTP_T2_CYC),
  parameter logic [31:0] OCP_T2_CYC = 32'(`OCP_T2_CYC)
) (
  // clock and reset
  input  logic        clk_sys,
  input  logic        reset_n,
  // apb slave
  input  logic [7:0]  paddr,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // protection indications from the analog side
  input  logic        over_temp_pin,
  input  logic        over_current_pin,
  input  logic        pwm_clk_pin,
  // audio serial inputs, two channels
  input  logic [1:0]  sck_pin,
  input  logic [1:0]  ws_pin,
  // power stage and audio path controls
  output logic        outputs_float,
  output logic        audio_path_en,
  output logic        clip_ctrl_en,
  output logic [1:0]  pwm_rate,
  // interrupt
  output logic        irq
);
  localparam logic [10:0] UFP_CNT = 11'(`UFP_PERIOD_CYC - 1);
  localparam logic [10:0] OFP_CNT = 11'(`OFP_PERIOD_CYC - 1);
  localparam logic [7:0]  RATIOS [5] = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h80};

  logic [31:0] ctrl;
  logic [4:0]  irq_status;
  logic [4:0]  irq_enable;
  logic [4:0]  faults;
  logic [4:0]  faults_prev;
  logic [6:0]  pins_s;
  logic        otp_s;
  logic        ocp_s;
  logic        pwm_s;
  logic [1:0]  sck_s;
  logic [1:0]  ws_s;
  logic        wr_en;
  logic        rd_setup;
  logic        ctrl_wr;
  logic        clr_wr;
  logic        mode_restart;
  logic        amp_enable;
  logic        input_select;
  logic        thermal_fault;
  logic        current_fault;
  logic        underrate_fault;
  logic        overrate_fault;
  logic        bad_bitclock_fault;
  logic        pwm_prev;
  logic        pwm_edge;
  logic [10:0] pwm_cnt;
  logic        sck_prev;
  logic        ws_prev;
  logic        sck_edge;
  logic        ws_edge;
  logic [7:0]  bclk_cnt;
  logic [3:0]  sample_rate_select;

  // pwm family of a sample rate code; codes 12 to 15 are unused
  function automatic fault_pkg::pwm_rate_e fs_family(input logic [3:0] fs);
    case (fs)
      4'h0, 4'h3, 4'h6, 4'h9: fs_family = fault_pkg::PWM_256K;
      4'h1, 4'h4, 4'h7, 4'hA: fs_family = fault_pkg::PWM_352K8;
      default:                fs_family = fault_pkg::PWM_384K;
    endcase
  endfunction

  // true when a bit clock count is within one of a valid ratio
  function automatic logic ratio_ok(input logic [7:0] c);
    ratio_ok = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (c + 8'h01 >= RATIOS[i] && c <= RATIOS[i] + 8'h01) begin
        ratio_ok = 1'b1;
      end
    end
  endfunction

  // true for an offset that the slave maps
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `OFF_CTRL) || (a == `OFF_FAULT_CLR) || (a == `OFF_STATUS) ||
              (a == `OFF_IRQ_STAT) || (a == `OFF_IRQ_EN) || (a == `OFF_IRQ_CLR);
  endfunction

  // every pin goes through two flops before use
  pin_sync #(
    .W (7)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .d       ({over_temp_pin, over_current_pin, pwm_clk_pin, sck_pin, ws_pin}),
    .q       (pins_s)
  );
  assign {otp_s, ocp_s, pwm_s, sck_s, ws_s} = pins_s;

  // apb decode; reads are captured in setup, so no wait state is needed
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign ctrl_wr  = wr_en & (paddr == `OFF_CTRL);
  assign clr_wr   = wr_en & (paddr == `OFF_FAULT_CLR);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_ok(paddr);

  // control register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= `CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= pwdata & `CTRL_MASK;
    end
  end

  // control fields
  assign amp_enable         = ctrl[`CTRL_AMP_EN];
  assign input_select       = ctrl[`CTRL_INSEL];
  assign sample_rate_select = ctrl[`CTRL_FS +: 4];
  assign clip_ctrl_en       = ~ctrl[`CTRL_CLIP]; // R01
  assign pwm_rate           = fs_family(sample_rate_select); // R02

  // off to amplifier transition releases faults held without recovery
  assign mode_restart = ctrl_wr & pwdata[`CTRL_AMP_EN] & ~amp_enable; // R06 R09

  // thermal fault with its retry timer
  fault_latch #(
    .T0 (32'(`OTP_T0_CYC)),
    .T1 (OTP_T1_CYC),
    .T2 (OTP_T2_CYC)
  ) u_otp (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .cause        (otp_s),
    .sel          (fault_pkg::retry_sel_e'(ctrl[`CTRL_TSEL +: 2])),
    .host_clear   (clr_wr & pwdata[`CLR_THERM]),
    .mode_restart (mode_restart),
    .fault        (thermal_fault)
  );

  // over-current fault with its retry timer
  fault_latch #(
    .T0 (32'(`OCP_T0_CYC)),
    .T1 (32'(`OCP_T1_CYC)),
    .T2 (OCP_T2_CYC)
  ) u_ocp (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .cause        (ocp_s),
    .sel          (fault_pkg::retry_sel_e'(ctrl[`CTRL_CSEL +: 2])),
    .host_clear   (clr_wr & pwdata[`CLR_CURR]),
    .mode_restart (mode_restart),
    .fault        (current_fault)
  );

  // pwm clock edge detect on the synchronised level
  assign pwm_edge = pwm_s & ~pwm_prev;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pwm_prev <= 1'b0;
    end else begin
      pwm_prev <= pwm_s;
    end
  end

  // cycles since the last pwm edge; saturates so a stopped clock reads slow
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pwm_cnt <= 11'h000;
    end else if (pwm_edge) begin
      pwm_cnt <= 11'h000;
    end else if (pwm_cnt != 11'h7FF) begin
      pwm_cnt <= pwm_cnt + 11'h001;
    end
  end

  // under-rate: period too long, or no edge for that long
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      underrate_fault <= 1'b0;
    end else if (pwm_edge) begin
      underrate_fault <= (pwm_cnt >= UFP_CNT); // R10
    end else if (pwm_cnt >= UFP_CNT) begin
      underrate_fault <= 1'b1; // R10
    end
  end

  // over-rate: period too short; released once a period runs long enough
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      overrate_fault <= 1'b0;
    end else if (pwm_edge) begin
      overrate_fault <= (pwm_cnt <= OFP_CNT); // R11
    end else if (pwm_cnt > OFP_CNT) begin
      overrate_fault <= 1'b0; // R11
    end
  end

  // bit and word clock edges of the selected channel
  assign sck_edge = sck_s[input_select] & ~sck_prev;
  assign ws_edge  = ws_s[input_select] & ~ws_prev;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sck_prev <= 1'b0;
      ws_prev  <= 1'b0;
    end else begin
      sck_prev <= sck_s[input_select];
      ws_prev  <= ws_s[input_select];
    end
  end

  // bit clocks per word period; an edge on the word edge opens the next period
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bclk_cnt <= 8'h00;
    end else if (ws_edge) begin
      bclk_cnt <= sck_edge ? 8'h01 : 8'h00;
    end else if (sck_edge && bclk_cnt != 8'hFF) begin
      bclk_cnt <= bclk_cnt + 8'h01;
    end
  end

  // ratio judged once per word period; recovers by itself
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bad_bitclock_fault <= 1'b0;
    end else if (ws_edge) begin
      bad_bitclock_fault <= ~ratio_ok(bclk_cnt); // R03 R14
    end
  end

  // fault vector as seen in status
  assign faults = {bad_bitclock_fault, overrate_fault, underrate_fault,
                   current_fault, thermal_fault};

  // any fault, or off mode, floats the stages
  assign outputs_float = ~amp_enable | (|faults); // R04 R07 R10 R11 R13 R15
  assign audio_path_en = amp_enable & ~bad_bitclock_fault; // R13

  // rising fault edges are the interrupt events
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      faults_prev <= 5'h00;
    end else begin
      faults_prev <= faults;
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= 5'h00;
    end else if (wr_en && paddr == `OFF_IRQ_CLR) begin
      irq_status <= (irq_status & ~pwdata[4:0]) | (faults & ~faults_prev);
    end else begin
      irq_status <= irq_status | (faults & ~faults_prev);
    end
  end

  // interrupt enable register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_enable <= `IRQ_EN_RESET;
    end else if (wr_en && paddr == `OFF_IRQ_EN) begin
      irq_enable <= pwdata[4:0];
    end
  end

  assign irq = |(irq_status & irq_enable);

  // read data captured in the setup cycle; write-only words read zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        `OFF_CTRL:     prdata <= ctrl;
        `OFF_STATUS:   prdata <= {24'h00_0000, outputs_float, pwm_rate, faults}; // R12
        `OFF_IRQ_STAT: prdata <= {27'h000_0000, irq_status};
        `OFF_IRQ_EN:   prdata <= {27'h000_0000, irq_enable};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_ctrl_write;
    psel && penable && pwrite && paddr == `OFF_CTRL;
  endsequence

  sequence s_status_read;
    psel && !penable && !pwrite && paddr == `OFF_STATUS ##1 psel && penable;
  endsequence

  a_clip_map: assert property ( // R01
    s_ctrl_write |=> clip_ctrl_en == !$past(pwdata[`CTRL_CLIP]))
    else $error("clip control does not follow select");
  a_pwm_family: assert property ( // R02
    s_ctrl_write |=> pwm_rate == fs_family($past(pwdata[`CTRL_FS +: 4])))
    else $error("pwm rate does not follow sample rate");
  a_thermal_float: assert property ( // R04
    otp_s |=> thermal_fault && outputs_float)
    else $error("over temperature did not float outputs");
  a_current_float: assert property ( // R07
    ocp_s |=> current_fault && outputs_float)
    else $error("over current did not float outputs");
  a_underrate_set: assert property ( // R10
    (!pwm_edge && pwm_cnt >= UFP_CNT) |=> underrate_fault && outputs_float)
    else $error("slow pwm not flagged");
  a_overrate_set: assert property ( // R11
    (pwm_edge && pwm_cnt <= OFP_CNT) |=> overrate_fault && outputs_float)
    else $error("fast pwm not flagged");
  a_status_poll: assert property ( // R12
    s_status_read |-> prdata[4:0] == $past(faults))
    else $error("status does not show faults");
  a_bitclock_cut: assert property ( // R13
    (ws_edge && !ratio_ok(bclk_cnt)) |=> bad_bitclock_fault && !audio_path_en)
    else $error("bad bit clock did not cut audio");
  a_ratio_restart: assert property ( // R14
    (ws_edge && ratio_ok(bclk_cnt) && amp_enable && !ctrl_wr) |=> audio_path_en)
    else $error("valid ratio did not restart audio");
  a_float_any: assert property ( // R15
    (amp_enable && $fell(|faults) && !ctrl_wr) |-> !outputs_float ##1 1'b1)
    else $error("outputs stay floating with no fault");
endmodule

// [rtl/amp_fault_cfg.svh]
`ifndef AMP_FAULT_CFG_SVH
`define AMP_FAULT_CFG_SVH
// register byte offsets
`define OFF_CTRL      8'h00
`define OFF_FAULT_CLR 8'h04
`define OFF_STATUS    8'h08
`define OFF_IRQ_STAT  8'h0C
`define OFF_IRQ_EN    8'h10
`define OFF_IRQ_CLR   8'h14
// control register fields and reset value
`define CTRL_AMP_EN   0
`define CTRL_CLIP     1
`define CTRL_TSEL     2
`define CTRL_CSEL     4
`define CTRL_INSEL    6
`define CTRL_FS       8
`define CTRL_MASK     32'h0000_0F7F
`define CTRL_RESET    32'h0000_0800
// fault clear fields
`define CLR_THERM     0
`define CLR_CURR      1
// status register fields
`define ST_RATE       5
`define ST_FLOAT      7
// interrupt enable reset value
`define IRQ_EN_RESET  5'h00
// system clock rate
`define CLK_MHZ       100
`define CLK_KHZ       100000
// retry delays in their own units
`define OTP_T0_NS     4500
`define OTP_T1_MS     100
`define OTP_T2_S      1
`define OCP_T0_NS     4500
`define OCP_T1_NS     27500
`define OCP_T2_MS     10
// retry delays in cycles, least times round up
`define NS_TO_CYC(t)  (((t) * `CLK_MHZ + 999) / 1000)
`define OTP_T0_CYC    `NS_TO_CYC(`OTP_T0_NS)
`define OTP_T1_CYC    ((`OTP_T1_MS) * `CLK_MHZ * 1000)
`define OTP_T2_CYC    ((`OTP_T2_S) * `CLK_MHZ * 1000000)
`define OCP_T0_CYC    `NS_TO_CYC(`OCP_T0_NS)
`define OCP_T1_CYC    `NS_TO_CYC(`OCP_T1_NS)
`define OCP_T2_CYC    ((`OCP_T2_MS) * `CLK_MHZ * 1000)
// pwm rate limits and their periods in cycles
`define UFP_KHZ       96
`define OFP_KHZ       1031
`define UFP_PERIOD_CYC ((`CLK_KHZ + `UFP_KHZ - 1) / `UFP_KHZ)
`define OFP_PERIOD_CYC (`CLK_KHZ / `OFP_KHZ)
`endif

// [rtl/fault_pkg.sv]
package fault_pkg;
  // pwm rate family, codes for 256, 352.8 and 384 khz
  typedef enum logic [1:0] {
    PWM_256K  = 2'h0,
    PWM_352K8 = 2'h1,
    PWM_384K  = 2'h3
  } pwm_rate_e;
  // retry delay selection
  typedef enum logic [1:0] {
    RETRY_T0   = 2'h0,
    RETRY_T1   = 2'h1,
    RETRY_T2   = 2'h2,
    RETRY_NONE = 2'h3
  } retry_sel_e;
  // fault latch states
  typedef enum logic [1:0] {
    LATCH_IDLE = 2'h0,
    LATCH_HELD = 2'h1,
    LATCH_WAIT = 2'h3
  } latch_state_e;
endpackage

// [rtl/pin_sync.sv]
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  logic         clk_sys,
  input  logic         reset_n,
  // asynchronous pins in, synchronised levels out
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // two flops; the first is read by the second only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// [rtl/fault_latch.sv]
module fault_latch #(
  parameter logic [31:0] T0 = 32'h0000_0001,
  parameter logic [31:0] T1 = 32'h0000_0001,
  parameter logic [31:0] T2 = 32'h0000_0001
) (
  // clock and reset
  input  logic                  clk_sys,
  input  logic                  reset_n,
  // cause and recovery controls
  input  logic                  cause,
  input  fault_pkg::retry_sel_e sel,
  input  logic                  host_clear,
  input  logic                  mode_restart,
  // latched fault
  output logic                  fault
);
  fault_pkg::latch_state_e state;
  logic [31:0]             wait_cnt;
  logic [31:0]             delay;

  // retry delay of the selected setting
  always_comb begin
    unique case (sel)
      fault_pkg::RETRY_T0:   delay = T0;
      fault_pkg::RETRY_T1:   delay = T1;
      fault_pkg::RETRY_T2:   delay = T2;
      fault_pkg::RETRY_NONE: delay = T0;
    endcase
  end

  // a live cause always wins over any clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= fault_pkg::LATCH_IDLE;
    end else begin
      unique case (state)
        fault_pkg::LATCH_IDLE: begin
          if (cause) state <= fault_pkg::LATCH_HELD; // R04 R07
        end
        fault_pkg::LATCH_HELD: begin
          if (cause) state <= fault_pkg::LATCH_HELD;
          else if (host_clear || mode_restart) state <= fault_pkg::LATCH_IDLE; // R06 R09
          else if (sel != fault_pkg::RETRY_NONE) state <= fault_pkg::LATCH_WAIT; // R05 R08
        end
        fault_pkg::LATCH_WAIT: begin
          if (cause) state <= fault_pkg::LATCH_HELD;
          else if (host_clear || mode_restart) state <= fault_pkg::LATCH_IDLE;
          // switching to no recovery mid-wait must keep the fault latched
          else if (sel == fault_pkg::RETRY_NONE) state <= fault_pkg::LATCH_HELD; // R06 R09
          else if (wait_cnt == 32'h0) state <= fault_pkg::LATCH_IDLE; // R05 R08
        end
        default: state <= fault_pkg::LATCH_IDLE;
      endcase
    end
  end

  // retry timer, loaded while the fault is held
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt <= 32'h0;
    end else if (state == fault_pkg::LATCH_HELD) begin
      wait_cnt <= delay - 32'h1;
    end else if (state == fault_pkg::LATCH_WAIT && wait_cnt != 32'h0) begin
      wait_cnt <= wait_cnt - 32'h1;
    end
  end

  assign fault = (state != fault_pkg::LATCH_IDLE);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_cause_latches: assert property (cause |=> fault) // R04 R07
    else $error("fault not latched on cause");
  a_no_recovery: assert property ( // R06 R09
    (fault && !cause && sel == fault_pkg::RETRY_NONE && !host_clear && !mode_restart)
      |=> fault)
    else $error("unrecoverable fault cleared by itself");
  a_retry_expiry: assert property ( // R05 R08
    (state == fault_pkg::LATCH_WAIT && wait_cnt == 32'h0 && !cause &&
     sel != fault_pkg::RETRY_NONE) |=> !fault)
    else $error("fault not cleared at timer expiry");
endmodule

// [testbench/signal_source_model.sv]
module signal_source_model (
  // rates chosen by the bench
  input  wire logic [7:0]  ratio,
  input  wire logic [15:0] pwm_half_ns,
  // serial clocks of both channels and the pwm clock
  output logic [1:0]       sck_pin,
  output logic [1:0]       ws_pin,
  output logic             pwm_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt0;
  int cnt1;

  // everything starts low so the first edges are clean
  initial begin
    sck_pin = 2'h0;
    ws_pin = 2'h0;
    pwm_clk_pin = 1'b0;
    cnt0 = 0;
    cnt1 = 0;
  end

  // bit clock of 80 ns; word clock moves on falling bit clock so rises never race
  always begin
    #40;
    sck_pin = ~sck_pin;
    if (sck_pin[0] == 1'b0) begin
      cnt0 = (cnt0 + 1) % int'(ratio);
      cnt1 = (cnt1 + 1) % 32;
      ws_pin[0] = (cnt0 < int'(ratio) / 2);
      ws_pin[1] = (cnt1 < 16);
    end
  end

  // pwm clock, half period in ns set by the bench
  always begin
    #(pwm_half_ns);
    pwm_clk_pin = ~pwm_clk_pin;
  end
endmodule

// [testbench/amp_fault_protection_supervisor_tb.sv]
`include "amp_fault_cfg.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module amp_fault_protection_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        over_temp_pin = 1'b0;
  logic        over_current_pin = 1'b0;
  logic        pwm_clk_pin;
  logic [1:0]  sck_pin;
  logic [1:0]  ws_pin;
  logic        outputs_float;
  logic        audio_path_en;
  logic        clip_ctrl_en;
  logic [1:0]  pwm_rate;
  logic        irq;
  logic [7:0]  ratio = 8'h20;
  logic [15:0] pwm_half_ns = 16'h0516;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          dly [2][4] = '{'{450, 20, 30, 0}, '{450, 2750, 40, 0}};
  int          rt [9] = '{16, 17, 18, 32, 48, 64, 96, 128, 129};
  logic        bad [9] = '{0, 0, 1, 0, 0, 0, 1, 0, 0};

  always #5 clk_sys = ~clk_sys;

  // short retry counts keep the run brief
  amp_fault_protection_supervisor #(.OTP_T1_CYC(32'd20), .OTP_T2_CYC(32'd30),
    .OCP_T2_CYC(32'd40)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .over_temp_pin(over_temp_pin),
    .over_current_pin(over_current_pin), .pwm_clk_pin(pwm_clk_pin), .sck_pin(sck_pin),
    .ws_pin(ws_pin), .outputs_float(outputs_float), .audio_path_en(audio_path_en),
    .clip_ctrl_en(clip_ctrl_en), .pwm_rate(pwm_rate), .irq(irq));

  signal_source_model src (.ratio(ratio), .pwm_half_ns(pwm_half_ns), .sck_pin(sck_pin),
    .ws_pin(ws_pin), .pwm_clk_pin(pwm_clk_pin));

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 90000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // one apb transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // the write lands at the access edge; one more edge lets its effect settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge clk_sys);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  task automatic st_chk(input logic [4:0] e);
    apb(1'b0, `OFF_STATUS, 32'h0000_0000);
    `CHK(rd[4:0], e)
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // raise a thermal or current fault, then recover it the way the retry field says
  task automatic fault_run(input int k, input int s);
    logic [31:0] c;
    c = 32'h0000_0801 | (32'(s) << (2 + 2 * k));
    wr(`OFF_CTRL, c);
    if (k == 0) over_temp_pin <= 1'b1;
    else over_current_pin <= 1'b1;
    wait_cyc(4);
    `CHK(outputs_float, 1'b1)
    st_chk(5'(1 << k));
    if (k == 0) over_temp_pin <= 1'b0;
    else over_current_pin <= 1'b0;
    if (s == 3) begin
      wait_cyc(100);
      st_chk(5'(1 << k));
      if (k == 0) begin
        wr(`OFF_CTRL, c & 32'hFFFF_FFFE);
        wr(`OFF_CTRL, c);
      end else wr(`OFF_FAULT_CLR, 32'(1 << k));
    end else begin
      wait_cyc(dly[k][s] / 2);
      st_chk(5'(1 << k));
      wait_cyc(dly[k][s]);
    end
    wait_cyc(2);
    st_chk(5'h00);
    `CHK(outputs_float, 1'b0)
  endtask

  initial begin
    wait_cyc(16);
    reset_n <= 1'b1;
    wait_cyc(1);
    `CHK(outputs_float, 1'b1)
    `CHK(pwm_rate, 2'h3)
    `CHK(clip_ctrl_en, 1'b1)
    rchk(`OFF_CTRL, `CTRL_RESET);
    `CHK(err, 1'b0)
    rchk(`OFF_IRQ_EN, 32'h0000_0000);
    rchk(8'h18, 32'h0000_0000);
    `CHK(err, 1'b1)
    wr(`OFF_CTRL, 32'hFFFF_FFFF);
    rchk(`OFF_CTRL, `CTRL_MASK);
    // every sample rate code 0 to 11 lands in its pwm family
    for (int i = 0; i < 12; i++) begin
      wr(`OFF_CTRL, 32'(i) << `CTRL_FS);
      `CHK(pwm_rate, (i % 3 == 2) ? 2'h3 : 2'(i % 3))
    end
    wr(`OFF_CTRL, 32'h0000_0802);
    `CHK(clip_ctrl_en, 1'b0)
    wr(`OFF_CTRL, 32'h0000_0801);
    `CHK(clip_ctrl_en, 1'b1)
    wait_cyc(3000);
    wr(`OFF_IRQ_CLR, 32'h0000_001F);
    `CHK(outputs_float, 1'b0)
    `CHK(audio_path_en, 1'b1)
    wr(`OFF_IRQ_EN, 32'h0000_0001);
    for (int k = 0; k < 2; k++) for (int s = 0; s < 4; s++) fault_run(k, s);
    `CHK(irq, 1'b1)
    rchk(`OFF_IRQ_STAT, 32'h0000_0003);
    wr(`OFF_IRQ_CLR, 32'h0000_001F);
    `CHK(irq, 1'b0)
    wr(`OFF_IRQ_EN, 32'h0000_0000);
    // pwm too slow, masked interrupt, then a current fault outlasting it
    wr(`OFF_CTRL, 32'h0000_0831);
    pwm_half_ns <= 16'd6000;
    wait_cyc(2500);
    st_chk(5'h04);
    `CHK(outputs_float, 1'b1)
    `CHK(irq, 1'b0)
    wr(`OFF_IRQ_EN, 32'h0000_0004);
    `CHK(irq, 1'b1)
    wr(`OFF_IRQ_CLR, 32'h0000_0004);
    wait_cyc(1);
    `CHK(irq, 1'b0)
    over_current_pin <= 1'b1;
    pwm_half_ns <= 16'd1302;
    wait_cyc(2000);
    over_current_pin <= 1'b0;
    st_chk(5'h02);
    `CHK(outputs_float, 1'b1)
    wr(`OFF_FAULT_CLR, 32'h0000_0002);
    wait_cyc(2);
    `CHK(outputs_float, 1'b0)
    pwm_half_ns <= 16'd400;
    wait_cyc(300);
    st_chk(5'h08);
    `CHK(outputs_float, 1'b1)
    pwm_half_ns <= 16'd1302;
    wait_cyc(500);
    st_chk(5'h00);
    // bit clock ratios around the accepted values
    for (int i = 0; i < 9; i++) begin
      ratio <= 8'(rt[i]);
      wait_cyc(rt[i] * 24 + 50);
      st_chk({bad[i], 4'h0});
      `CHK(audio_path_en, ~bad[i])
      `CHK(outputs_float, bad[i])
    end
    // a bad ratio on the other channel is ignored
    ratio <= 8'd40;
    wr(`OFF_CTRL, 32'h0000_0841);
    wait_cyc(1000);
    st_chk(5'h00);
    wr(`OFF_CTRL, 32'h0000_0801);
    wait_cyc(1000);
    st_chk(5'h10);
    give_verdict();
  end
endmodule
